/* File: pkg/exec_pkg.sv */
package exec_pkg;

  // Operation selected by the instruction stream, one-hot
  typedef enum logic [11:0] {
    op_sum          = 12'h001,
    op_sum_carry    = 12'h002,
    op_conj_acc     = 12'h004,
    op_conj_dir_acc = 12'h008,
    op_conj_dir_imm = 12'h010,
    op_conj_bit     = 12'h020,
    op_conj_nbit    = 12'h040,
    op_cmp_branch   = 12'h080,
    op_full_jump    = 12'h100,
    op_full_call    = 12'h200,
    op_page_jump    = 12'h400,
    op_page_call    = 12'h800
  } op_t;

  // Source operand addressing, one-hot
  typedef enum logic [3:0] {
    src_bank     = 4'h1,
    src_direct   = 4'h2,
    src_indirect = 4'h4,
    src_imm      = 4'h8
  } src_t;

  // Left-hand side of a compare, one-hot
  typedef enum logic [2:0] {
    lhs_acc      = 3'h1,
    lhs_bank     = 3'h2,
    lhs_indirect = 3'h4
  } lhs_t;

  // Branch target formation, one-hot
  typedef enum logic [2:0] {
    tgt_full = 3'h1,
    tgt_page = 3'h2,
    tgt_rel  = 3'h4
  } tgt_t;

  localparam int          PC_W        = 16;
  localparam int          PAGE_W      = 11;
  localparam logic [7:0]  SFR_BASE    = 8'h80;
  localparam logic [7:0]  BIT_RAM     = 8'h20;
  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic        CARRY_RESET = 1'b0;
  localparam logic [15:0] TGT_RESET   = 16'h0000;
  localparam int          RAM_DEPTH   = 256;

endpackage

/* File: src/branch_target.sv */
`timescale 1ns/1ps
module branch_target (
  // Target selection
  input  wire exec_pkg::tgt_t kind,
  input  wire logic [15:0]    next_pc,
  // Instruction fields
  input  wire logic [7:0]     byte1,
  input  wire logic [7:0]     byte2,
  input  wire logic [2:0]     page_hi,
  // Result
  output logic [15:0]         target
);

  // Candidate targets
  wire [15:0] full_tgt = {byte1, byte2};
  wire [15:0] page_tgt = {next_pc[exec_pkg::PC_W-1:exec_pkg::PAGE_W], page_hi, byte1};
  wire [15:0] rel_tgt  = next_pc + {{8{byte2[7]}}, byte2};

  // Select by kind
  always_comb begin
    unique case (kind)
      exec_pkg::tgt_full: target = full_tgt;
      exec_pkg::tgt_page: target = page_tgt;
      exec_pkg::tgt_rel:  target = rel_tgt;
      default:            target = full_tgt;
    endcase
  end

endmodule // branch_target

/* File: src/op_exec.sv */
`timescale 1ns/1ps
module op_exec (
  // Clock and reset
  input  wire logic           core_clk,
  input  wire logic           reset,
  // Instruction stream
  input  wire logic           instr_valid,
  input  wire exec_pkg::op_t  op,
  input  wire exec_pkg::src_t src_mode,
  input  wire exec_pkg::lhs_t lhs_mode,
  input  wire logic [2:0]     bank_index,
  input  wire logic           pointer_sel,
  input  wire logic [7:0]     byte1,
  input  wire logic [7:0]     byte2,
  input  wire logic [2:0]     page_hi,
  input  wire logic [15:0]    next_pc,
  input  wire logic [1:0]     bank_select,
  // Special function register port
  output logic [7:0]          sfr_rd_addr,
  input  wire logic [7:0]     sfr_rdata,
  output logic                sfr_we,
  output logic [7:0]          sfr_addr,
  output logic [7:0]          sfr_wdata,
  // Core state and branch result
  output logic [7:0]          acc,
  output logic                carry,
  output logic                branch,
  output logic                branch_call,
  output logic [15:0]         branch_addr
);

  // Helpers for direct and bit addressing
  function automatic logic is_sfr(input logic [7:0] a);
    return a >= exec_pkg::SFR_BASE;
  endfunction

  function automatic logic [7:0] bit_byte(input logic [7:0] b);
    return b[7] ? {b[7:3], 3'h0} : exec_pkg::BIT_RAM + {4'h0, b[6:3]};
  endfunction

  logic [7:0]  ram [exec_pkg::RAM_DEPTH];
  logic [7:0]  acc_q;
  logic [7:0]  acc_d;
  logic        carry_q;
  logic        carry_d;
  logic        branch_q;
  logic        call_q;
  logic [15:0] target_q;
  logic        sfr_we_q;
  logic [7:0]  sfr_addr_q;
  logic [7:0]  sfr_wdata_q;
  logic [7:0]  src_byte;
  logic [7:0]  lhs_byte;
  logic [15:0] target;
  exec_pkg::tgt_t tgt_kind;

  // Operation decode
  wire is_bitop   = (op == exec_pkg::op_conj_bit) || (op == exec_pkg::op_conj_nbit);
  wire is_dirwr   = (op == exec_pkg::op_conj_dir_acc) || (op == exec_pkg::op_conj_dir_imm);
  wire is_sumop   = (op == exec_pkg::op_sum) || (op == exec_pkg::op_sum_carry);
  wire is_full    = (op == exec_pkg::op_full_jump) || (op == exec_pkg::op_full_call);
  wire is_page    = (op == exec_pkg::op_page_jump) || (op == exec_pkg::op_page_call);
  wire is_call    = (op == exec_pkg::op_full_call) || (op == exec_pkg::op_page_call);

  // Operand addresses
  wire [7:0] bank_addr = {3'h0, bank_select, bank_index};
  wire [7:0] ptr_slot  = {3'h0, bank_select, 2'h0, pointer_sel};
  wire [7:0] ptr_addr  = ram[ptr_slot];
  wire [7:0] bit_addr  = bit_byte(byte1);
  wire [7:0] dir_addr  = is_bitop ? bit_addr : byte1;
  wire [7:0] dir_byte  = is_sfr(dir_addr) ? sfr_rdata : ram[dir_addr];
  wire       bit_val   = dir_byte[byte1[2:0]];

  // Arithmetic and logic results
  wire       cin       = (op == exec_pkg::op_sum_carry) ? carry_q : 1'b0;
  wire [8:0] sum_full  = {1'b0, acc_q} + {1'b0, src_byte} + {8'h00, cin};
  wire [7:0] dir_wdata = dir_byte & ((op == exec_pkg::op_conj_dir_acc) ? acc_q : byte2);
  wire       bit_term  = (op == exec_pkg::op_conj_nbit) ? ~bit_val : bit_val;
  wire       differ    = (lhs_byte != src_byte);
  wire       take      = instr_valid && (is_full || is_page ||
                         ((op == exec_pkg::op_cmp_branch) && differ));

  assign sfr_rd_addr = dir_addr;

  // Source byte selection
  always_comb begin
    unique case (src_mode)
      exec_pkg::src_bank:     src_byte = ram[bank_addr];
      exec_pkg::src_direct:   src_byte = dir_byte;
      exec_pkg::src_indirect: src_byte = ram[ptr_addr];
      exec_pkg::src_imm:      src_byte = byte1;
      default:                src_byte = byte1;
    endcase
  end

  // Compare left-hand byte
  always_comb begin
    unique case (lhs_mode)
      exec_pkg::lhs_acc:      lhs_byte = acc_q;
      exec_pkg::lhs_bank:     lhs_byte = ram[bank_addr];
      exec_pkg::lhs_indirect: lhs_byte = ram[ptr_addr];
      default:                lhs_byte = acc_q;
    endcase
  end

  // Target kind
  always_comb begin
    if (is_full) begin
      tgt_kind = exec_pkg::tgt_full;
    end else if (is_page) begin
      tgt_kind = exec_pkg::tgt_page;
    end else begin
      tgt_kind = exec_pkg::tgt_rel;
    end
  end

  branch_target branch_target_i (
    .kind    (tgt_kind),
    .next_pc (next_pc),
    .byte1   (byte1),
    .byte2   (byte2),
    .page_hi (page_hi),
    .target  (target)
  );

  // Accumulator and carry next values
  always_comb begin
    acc_d   = acc_q;
    carry_d = carry_q;
    if (instr_valid) begin
      if (is_sumop) begin
        acc_d   = sum_full[7:0];
        carry_d = sum_full[8];
      end else if (op == exec_pkg::op_conj_acc) begin
        acc_d   = acc_q & src_byte;
      end else if (is_bitop) begin
        carry_d = carry_q & bit_term;
      end
    end
  end

  // Core state registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      acc_q   <= exec_pkg::ACC_RESET;
      carry_q <= exec_pkg::CARRY_RESET;
    end else begin
      acc_q   <= acc_d;
      carry_q <= carry_d;
    end
  end

  // Branch result registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      branch_q <= 1'b0;
      call_q   <= 1'b0;
      target_q <= exec_pkg::TGT_RESET;
    end else begin
      branch_q <= take;
      call_q   <= instr_valid && is_call;
      target_q <= take ? target : target_q;
    end
  end

  // Direct byte write to a special register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sfr_we_q    <= 1'b0;
      sfr_addr_q  <= 8'h00;
      sfr_wdata_q <= 8'h00;
    end else begin
      sfr_we_q    <= instr_valid && is_dirwr && is_sfr(byte1);
      sfr_addr_q  <= byte1;
      sfr_wdata_q <= dir_wdata;
    end
  end

  // Direct byte write to data RAM, no reset on storage
  always_ff @(posedge core_clk) begin
    if (!reset && instr_valid && is_dirwr && !is_sfr(byte1)) begin
      ram[byte1] <= dir_wdata;
    end
  end

  assign acc         = acc_q;
  assign carry       = carry_q;
  assign branch      = branch_q;
  assign branch_call = call_q;
  assign branch_addr = target_q;
  assign sfr_we      = sfr_we_q;
  assign sfr_addr    = sfr_addr_q;
  assign sfr_wdata   = sfr_wdata_q;

  // Checks
  chk_plain_sum: assert property (@(posedge core_clk) disable iff (reset)
    instr_valid && op == exec_pkg::op_sum |=>
      {carry_q, acc_q} == ({1'b0, $past(acc_q)} + {1'b0, $past(src_byte)}))
    else $error("plain sum result wrong");

  chk_carry_sum: assert property (@(posedge core_clk) disable iff (reset)
    instr_valid && op == exec_pkg::op_sum_carry |=>
      {carry_q, acc_q} == ({1'b0, $past(acc_q)} + {1'b0, $past(src_byte)}
                           + {8'h00, $past(carry_q)}))
    else $error("sum with carry result wrong");

  chk_acc_conj: assert property (@(posedge core_clk) disable iff (reset)
    instr_valid && op == exec_pkg::op_conj_acc |=>
      acc_q == ($past(acc_q) & $past(src_byte)) && carry_q == $past(carry_q))
    else $error("accumulator conjunction wrong");

  chk_bit_conj: assert property (@(posedge core_clk) disable iff (reset)
    instr_valid && op == exec_pkg::op_conj_nbit |=>
      carry_q == ($past(carry_q) & ~$past(bit_val)) && acc_q == $past(acc_q))
    else $error("complement bit conjunction wrong");

  chk_bit_plain: assert property (@(posedge core_clk) disable iff (reset)
    instr_valid && op == exec_pkg::op_conj_bit |=>
      carry_q == ($past(carry_q) & $past(bit_val)) && acc_q == $past(acc_q))
    else $error("bit conjunction wrong");

  chk_cmp_branch: assert property (@(posedge core_clk) disable iff (reset)
    instr_valid && op == exec_pkg::op_cmp_branch |=>
      branch_q == ($past(lhs_byte) != $past(src_byte)) && !call_q)
    else $error("compare branch decision wrong");

  chk_rel_target: assert property (@(posedge core_clk) disable iff (reset)
    instr_valid && op == exec_pkg::op_cmp_branch && differ |=>
      branch_addr == $past(next_pc) + {{8{$past(byte2[7])}}, $past(byte2)})
    else $error("relative target wrong");

  chk_full_target: assert property (@(posedge core_clk) disable iff (reset)
    instr_valid && op == exec_pkg::op_full_call |=>
      branch_q && call_q && branch_addr == {$past(byte1), $past(byte2)})
    else $error("full target wrong");

  chk_page_target: assert property (@(posedge core_clk) disable iff (reset)
    instr_valid && is_page |=>
      branch_addr[15:11] == $past(next_pc[15:11])
      && branch_addr[10:0] == {$past(page_hi), $past(byte1)})
    else $error("page target wrong");

  chk_sfr_write: assert property (@(posedge core_clk) disable iff (reset)
    instr_valid && is_dirwr |=>
      sfr_we_q == ($past(byte1) >= exec_pkg::SFR_BASE) && sfr_addr_q == $past(byte1))
    else $error("special register write decode wrong");

  chk_idle_hold: assert property (@(posedge core_clk) disable iff (reset)
    !instr_valid |=> !branch_q && acc_q == $past(acc_q) && carry_q == $past(carry_q))
    else $error("state changed without instruction");

endmodule // op_exec

/* File: tb/mcu_operand_and_op_semantics_bench.sv */
`timescale 1ns/1ps
module mcu_operand_and_op_semantics_bench;
  typedef struct packed {
    exec_pkg::op_t  op;
    exec_pkg::src_t src;
    logic [7:0]     b1;
    logic [7:0]     rd;
    logic [7:0]     acc;
    logic           c;
  } row_t;
  // Design inputs
  logic            core_clk    = 1'b0;
  logic            reset       = 1'b1;
  logic            instr_valid = 1'b0;
  exec_pkg::op_t   op          = exec_pkg::op_sum;
  exec_pkg::src_t  src_mode    = exec_pkg::src_imm;
  exec_pkg::lhs_t  lhs_mode    = exec_pkg::lhs_acc;
  logic [2:0]      bank_index  = 3'h0;
  logic            pointer_sel = 1'b0;
  logic [7:0]      byte1       = 8'h00;
  logic [7:0]      byte2       = 8'h00;
  logic [2:0]      page_hi     = 3'h0;
  logic [15:0]     next_pc     = 16'h1000;
  logic [1:0]      bank_select = 2'h0;
  logic [7:0]      sfr_rdata   = 8'h00;
  // Design outputs
  logic [7:0]      sfr_rd_addr, sfr_addr, sfr_wdata, acc;
  logic            sfr_we, carry, branch, branch_call;
  logic [15:0]     branch_addr;
  int              n_fail, samples_checked, cycles;
  row_t            rows [7];

  op_exec op_exec_i (.core_clk, .reset, .instr_valid, .op, .src_mode, .lhs_mode,
    .bank_index, .pointer_sel, .byte1, .byte2, .page_hi, .next_pc, .bank_select,
    .sfr_rd_addr, .sfr_rdata, .sfr_we, .sfr_addr, .sfr_wdata, .acc, .carry,
    .branch, .branch_call, .branch_addr);

  // Clock and cycle ceiling
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One instruction, inputs set at the falling edge
  task automatic run(input exec_pkg::op_t o, input exec_pkg::src_t s,
                     input logic [7:0] b1, input logic [7:0] b2);
    op = o;
    src_mode = s;
    byte1 = b1;
    byte2 = b2;
    instr_valid = 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic jmp(input exec_pkg::op_t o, input logic [15:0] exp, input logic call);
    run(o, exec_pkg::src_imm, 8'hab, 8'hcd);
    chk("branch and call", {14'h0, 1'b1, call}, {14'h0, branch, branch_call});
    chk("branch addr", exp, branch_addr);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Sums and conjunctions in sequence, accumulator carried along
  initial begin
    rows[0] = {exec_pkg::op_sum, exec_pkg::src_imm, 8'h05, 8'h00, 8'h05, 1'b0};
    rows[1] = {exec_pkg::op_sum, exec_pkg::src_imm, 8'hfe, 8'h00, 8'h03, 1'b1};
    rows[2] = {exec_pkg::op_sum_carry, exec_pkg::src_imm, 8'h10, 8'h00, 8'h14, 1'b0};
    rows[3] = {exec_pkg::op_sum, exec_pkg::src_direct, 8'h90, 8'hf0, 8'h04, 1'b1};
    rows[4] = {exec_pkg::op_sum_carry, exec_pkg::src_direct, 8'h80, 8'hff, 8'h04, 1'b1};
    rows[5] = {exec_pkg::op_conj_acc, exec_pkg::src_imm, 8'h06, 8'h00, 8'h04, 1'b1};
    rows[6] = {exec_pkg::op_conj_acc, exec_pkg::src_direct, 8'ha0, 8'h0c, 8'h04, 1'b1};
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    chk("reset state", 16'h0, {5'h0, carry, branch, sfr_we, acc});
    chk("reset target", 16'h0, branch_addr);
    foreach (rows[i]) begin
      sfr_rdata = rows[i].rd;
      run(rows[i].op, rows[i].src, rows[i].b1, 8'h00);
      chk("row acc", {8'h0, rows[i].acc}, {8'h0, acc});
      chk("row carry", {15'h0, rows[i].c}, {15'h0, carry});
    end
    // Direct byte writes on the special register port
    sfr_rdata = 8'ha5;
    run(exec_pkg::op_conj_dir_imm, exec_pkg::src_imm, 8'h90, 8'h3c);
    chk("sfr write", 16'h9024, {sfr_addr, sfr_wdata});
    chk("sfr we", 16'h1, {15'h0, sfr_we});
    sfr_rdata = 8'hff;
    run(exec_pkg::op_conj_dir_acc, exec_pkg::src_direct, 8'h91, 8'h00);
    chk("sfr write acc", 16'h9104, {sfr_addr, sfr_wdata});
    // Bit conjunction with the bit and its complement
    sfr_rdata = 8'h08;
    run(exec_pkg::op_conj_bit, exec_pkg::src_direct, 8'h93, 8'h00);
    chk("bit byte", 16'h90, {8'h0, sfr_rd_addr});
    chk("carry bit", 16'h1, {15'h0, carry});
    run(exec_pkg::op_conj_nbit, exec_pkg::src_direct, 8'h93, 8'h00);
    chk("carry nbit", 16'h0, {15'h0, carry});
    // Clear RAM bytes 0x0b, 0x09, 0x00; RAM writes stay off the port
    bank_select = 2'h1;
    run(exec_pkg::op_conj_dir_imm, exec_pkg::src_imm, 8'h0b, 8'h00);
    chk("ram no sfr we", 16'h0, {15'h0, sfr_we});
    run(exec_pkg::op_conj_dir_imm, exec_pkg::src_imm, 8'h09, 8'h00);
    run(exec_pkg::op_conj_dir_imm, exec_pkg::src_imm, 8'h00, 8'h00);
    run(exec_pkg::op_sum, exec_pkg::src_imm, 8'hff, 8'h00);
    bank_index = 3'h3;
    run(exec_pkg::op_sum, exec_pkg::src_bank, 8'h00, 8'h00);
    chk("bank sum", 16'h03, {7'h0, carry, acc});
    run(exec_pkg::op_sum, exec_pkg::src_imm, 8'hfe, 8'h00);
    pointer_sel = 1'b1;
    run(exec_pkg::op_sum_carry, exec_pkg::src_indirect, 8'h00, 8'h00);
    chk("indirect sum", 16'h02, {7'h0, carry, acc});
    // Compare and relative branch, both offset limits
    run(exec_pkg::op_cmp_branch, exec_pkg::src_imm, 8'h02, 8'h80);
    chk("cmp equal", 16'h0, {15'h0, branch});
    run(exec_pkg::op_cmp_branch, exec_pkg::src_imm, 8'h03, 8'h80);
    chk("cmp differ", 16'h0f81, {branch_addr[15:1], branch});
    lhs_mode = exec_pkg::lhs_indirect;
    run(exec_pkg::op_cmp_branch, exec_pkg::src_imm, 8'h00, 8'h7f);
    chk("cmp ind equal", 16'h0, {15'h0, branch});
    lhs_mode = exec_pkg::lhs_bank;
    run(exec_pkg::op_cmp_branch, exec_pkg::src_imm, 8'h01, 8'h7f);
    chk("cmp bank", 16'h107f, branch_addr);
    // Full and page targets
    next_pc = 16'hf7fe;
    page_hi = 3'h5;
    jmp(exec_pkg::op_full_jump, 16'habcd, 1'b0);
    jmp(exec_pkg::op_full_call, 16'habcd, 1'b1);
    jmp(exec_pkg::op_page_jump, 16'hf5ab, 1'b0);
    jmp(exec_pkg::op_page_call, 16'hf5ab, 1'b1);
    run(exec_pkg::op_sum, exec_pkg::src_imm, 8'h00, 8'h00);
    chk("pulse end", 16'hf5a8, {branch_addr[15:3], branch, branch_call, sfr_we});
    // No instruction presented: state holds, no pulses
    instr_valid = 1'b0;
    op = exec_pkg::op_page_call;
    @(posedge core_clk);
    @(negedge core_clk);
    chk("idle hold", 16'h0200, {acc, 5'h0, branch, branch_call, sfr_we});
    chk("idle target", 16'hf5ab, branch_addr);
    // Reset in mid-run, then the first instruction after release
    reset = 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    chk("mid reset", 16'h0, {acc, 5'h0, carry, branch, sfr_we} | branch_addr);
    reset = 1'b0;
    run(exec_pkg::op_sum, exec_pkg::src_imm, 8'h07, 8'h00);
    chk("after reset", 16'h07, {7'h0, carry, acc});
    end_sim();
  end
endmodule // mcu_operand_and_op_semantics_bench
